// ---- dird_top.sv ----
/*
 Input register and split decoder of a 14-bit current-output converter.
 Assumes samples arrive synchronous to clk with a valid/ready handshake;
 the analog cells sit outside and consume the registered controls.
*/
`timescale 1ns/1ps
`default_nettype none
module dird_top
    import dird_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Sample source
    input  wire logic                sample_valid,
    output logic                     sample_ready,
    input  wire logic [SAMPLE_W-1:0] sample_code_bits,
    // Current cell controls
    output logic [SAMPLE_W-1:0]      held_sample,
    output logic [BIN_W-1:0]         ladder_bits,
    output logic [SEG_N-1:0]         segment_en,
    output logic                     update_pulse
);
    // Thermometer decode, also reused by the check below
    function automatic logic [SEG_N-1:0] therm(input logic [SEG_IN_W-1:0] v);
        logic [SEG_N-1:0] t;
        t = '0;
        for (int k = 0; k < SEG_N; k++) begin
            t[k] = (v > k[SEG_IN_W-1:0]);
        end
        return t;
    endfunction : therm

    logic                buf_valid;
    logic [SAMPLE_W-1:0] buf_data;
    logic [SAMPLE_W-1:0] word_ff;
    logic [SEG_N-1:0]    seg_ff;
    logic [BIN_W-1:0]    bin_ff;
    logic                upd_ff;

    dird_buf2 #(.W(SAMPLE_W)) u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_code_bits),
        .out_valid (buf_valid),
        .out_ready (1'b1),
        .out_data  (buf_data)
    );

    // Upper field is bits 13..10, lower field 9..0
    wire [SEG_IN_W-1:0] nxt_upper = buf_data[MSB_POS -: SEG_IN_W];
    wire [BIN_W-1:0]    nxt_bin   = buf_data[BIN_W-1:LSB_POS];
    wire [SEG_N-1:0]    nxt_seg   = therm(nxt_upper);

    // Segments are registered with the word so all cells switch together,
    // trading one flop stage for lower glitch from decoder skew
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_ff <= RST_SAMPLE;
            seg_ff  <= '0;
            bin_ff  <= '0;
            upd_ff  <= 1'b0;
        end else begin
            upd_ff <= buf_valid;
            if (buf_valid) begin
                word_ff <= buf_data;
                seg_ff  <= nxt_seg;
                bin_ff  <= nxt_bin;
            end
        end
    end

    assign held_sample  = word_ff;
    assign ladder_bits  = bin_ff;
    assign segment_en   = seg_ff;
    assign update_pulse = upd_ff;

    property p_load_on_valid;
        @(posedge clk) disable iff (rst)
        buf_valid |=> (held_sample == $past(buf_data));
    endproperty
    a_load_on_valid: assert property (p_load_on_valid)
        else $error("word not loaded");

    property p_hold_idle;
        @(posedge clk) disable iff (rst)
        !buf_valid |=> $stable(held_sample) && !update_pulse;
    endproperty
    a_hold_idle: assert property (p_hold_idle)
        else $error("word changed without sample");

    property p_ladder;
        @(posedge clk) disable iff (rst)
        ladder_bits == held_sample[9:0];
    endproperty
    a_ladder: assert property (p_ladder)
        else $error("ladder bits mismatch");

    property p_seg_count;
        @(posedge clk) disable iff (rst)
        $countones(segment_en) == held_sample[13:10];
    endproperty
    a_seg_count: assert property (p_seg_count)
        else $error("segment count wrong");

    property p_therm_shape;
        @(posedge clk) disable iff (rst)
        segment_en == therm(held_sample[13:10]);
    endproperty
    a_therm_shape: assert property (p_therm_shape)
        else $error("segment pattern not thermometer");

    property p_msb_order;
        @(posedge clk) disable iff (rst)
        buf_valid && buf_data[13] |=> segment_en[7];
    endproperty
    a_msb_order: assert property (p_msb_order)
        else $error("bit 13 not treated as MSB");

    property p_full;
        @(posedge clk) disable iff (rst)
        held_sample == FULL_SCALE |-> (&segment_en) && (&ladder_bits);
    endproperty
    a_full: assert property (p_full)
        else $error("full scale not all on");

    property p_half;
        @(posedge clk) disable iff (rst)
        held_sample == HALF_SCALE |-> segment_en == 15'h00ff
            && ladder_bits == '0;
    endproperty
    a_half: assert property (p_half)
        else $error("half scale wrong");

    property p_zero;
        @(posedge clk) disable iff (rst)
        held_sample == RST_SAMPLE |-> segment_en == '0 && ladder_bits == '0;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero code not all off");

    property p_pulse;
        @(posedge clk) disable iff (rst)
        update_pulse |-> $past(buf_valid);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("update pulse without sample");

    // Drain never stalls, so the buffer can never fill
    property p_ready_free;
        @(posedge clk) disable iff (rst)
        sample_ready;
    endproperty
    a_ready_free: assert property (p_ready_free)
        else $error("input buffer refused a sample");

    property p_take_buf;
        @(posedge clk) disable iff (rst)
        sample_valid && sample_ready |=>
            buf_valid && (buf_data == $past(sample_code_bits));
    endproperty
    a_take_buf: assert property (p_take_buf)
        else $error("taken sample not buffered");

    property p_take_latency;
        @(posedge clk) disable iff (rst)
        sample_valid && sample_ready |-> ##2
            (update_pulse && (held_sample == $past(sample_code_bits, 2)));
    endproperty
    a_take_latency: assert property (p_take_latency)
        else $error("sample not loaded two cycles after take");

    property p_no_take_quiet;
        @(posedge clk) disable iff (rst)
        !(sample_valid && sample_ready) |-> ##2 !update_pulse;
    endproperty
    a_no_take_quiet: assert property (p_no_take_quiet)
        else $error("update without a taken sample");

    property p_stable_ctrl;
        @(posedge clk) disable iff (rst)
        !buf_valid |=> $stable(ladder_bits) && $stable(segment_en);
    endproperty
    a_stable_ctrl: assert property (p_stable_ctrl)
        else $error("cell controls changed without sample");

    property p_pulse_data;
        @(posedge clk) disable iff (rst)
        update_pulse |-> held_sample == $past(buf_data);
    endproperty
    a_pulse_data: assert property (p_pulse_data)
        else $error("update pulse with wrong word");

    property p_one_segment;
        @(posedge clk) disable iff (rst)
        held_sample[13:10] == 4'h1 |-> segment_en == 15'h0001;
    endproperty
    a_one_segment: assert property (p_one_segment)
        else $error("first segment carry wrong");

    // Thermometer form without the shared decode function
    property p_thermo_form;
        @(posedge clk) disable iff (rst)
        ((segment_en + 15'h0001) & segment_en) == 15'h0000;
    endproperty
    a_thermo_form: assert property (p_thermo_form)
        else $error("segment enables have a gap");

    property p_weight_sum;
        @(posedge clk) disable iff (rst)
        {4'($countones(segment_en)), ladder_bits} == held_sample;
    endproperty
    a_weight_sum: assert property (p_weight_sum)
        else $error("cell weights do not sum to the code");

    // Each enable checked alone, so one stuck cell is named by its index
    for (genvar k = 0; k < SEG_N; k++) begin : g_seg_chk
        property p_seg_bit;
            @(posedge clk) disable iff (rst)
            segment_en[k] == (held_sample[13:10] > k);
        endproperty
        a_seg_bit: assert property (p_seg_bit)
            else $error("segment enable out of order");
    end
endmodule : dird_top
`default_nettype wire

// ---- dird_pkg.sv ----
/*
 Constants for the converter input register and segment decoder.
 Assumes a single synchronous clock domain and one sample per valid beat.
*/
// What this block does
// - Register whole 14-bit word on rising edge
// - Bit 13 is MSB, bit 0 LSB
// - Ten low bits drive binary ladder directly
// - Four high bits become fifteen segment enables
// - Straight binary: zeros zero, ones full scale
`default_nettype none
package dird_pkg;
    localparam int SAMPLE_W   = 14;
    localparam int BIN_W      = 10;
    localparam int SEG_IN_W   = 4;
    localparam int SEG_N      = 15;
    localparam int MSB_POS    = 13;
    localparam int LSB_POS    = 0;
    localparam int BUF_DEPTH  = 2;
    localparam logic [13:0] RST_SAMPLE = 14'h0000;
    localparam logic [13:0] HALF_SCALE = 14'h2000;
    localparam logic [13:0] FULL_SCALE = 14'h3fff;
    localparam int MIN_RATE_KHZ = 100;
    localparam int MAX_RATE_KHZ = 100000;
    localparam int CLK_KHZ      = 250000;
    localparam int MIN_PERIOD_CYC = (CLK_KHZ + MAX_RATE_KHZ - 1) / MAX_RATE_KHZ;
endpackage : dird_pkg
`default_nettype wire

// ---- dird_buf2.sv ----
/*
 Two-entry valid/ready buffer in flip-flops.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dird_buf2
    import dird_pkg::*;
#(
    parameter int W = SAMPLE_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_ff [BUF_DEPTH];
    logic         rd_ptr_ff;
    logic         wr_ptr_ff;
    logic [1:0]   cnt_ff;
    wire          do_wr = in_valid && in_ready;
    wire          do_rd = out_valid && out_ready;

    // Full and empty are exact, so back-pressure reaches the source
    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else begin
            if (do_wr) begin
                mem_ff[wr_ptr_ff] <= in_data;
                wr_ptr_ff         <= ~wr_ptr_ff;
            end
            if (do_rd) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, do_wr} - {1'b0, do_rd};
        end
    end
endmodule : dird_buf2
`default_nettype wire

// ---- dird_src.sv ----
/*
 Sample source model feeding the converter front end.
 Assumes clk from the bench; words go out one at a time through send.
*/
`timescale 1ns/1ps
`default_nettype none
module dird_src
    import dird_pkg::*;
(
    // Clock
    input  wire logic                clk,
    // Sample stream
    output logic                     sample_valid,
    input  wire logic                sample_ready,
    output logic [SAMPLE_W-1:0]      sample_code_bits
);
    initial begin
        sample_valid     = 1'b0;
        sample_code_bits = 14'h0000;
    end
    // Released bus shows the inverse word, so stale data never matches
    task automatic send(input logic [SAMPLE_W-1:0] word, input int gap);
        @(posedge clk);
        #1;
        sample_valid     = 1'b1;
        sample_code_bits = word;
        do @(posedge clk); while (sample_ready !== 1'b1);
        #1;
        sample_valid     = 1'b0;
        sample_code_bits = ~word;
        // Never faster than the top sample rate
        repeat (gap + MIN_PERIOD_CYC - 2) @(posedge clk);
    endtask : send
endmodule : dird_src
`default_nettype wire

// ---- testbench.sv ----
/*
 Self-checking bench for the converter front end.
 Assumes the source model drives all sample inputs of the top module.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
    mismatches++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
    import dird_pkg::*;
    logic                clk;
    logic                rst;
    logic                sample_valid;
    logic                sample_ready;
    logic [SAMPLE_W-1:0] sample_code_bits;
    logic [SAMPLE_W-1:0] held_sample;
    logic [BIN_W-1:0]    ladder_bits;
    logic [SEG_N-1:0]    segment_en;
    logic                update_pulse;
    int                  mismatches = 0;
    int                  tests_run = 0;
    int                  cycles = 0;
    int                  seed = 79;
    logic [SAMPLE_W-1:0] exp_q[$];
    logic [SAMPLE_W-1:0] last_w = RST_SAMPLE;
    logic [SAMPLE_W-1:0] corner[5] = '{14'h0000, 14'h3fff, 14'h2000,
                                       14'h03ff, 14'h0400};

    dird_top i_dird_top (.clk(clk), .rst(rst), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_code_bits(sample_code_bits),
        .held_sample(held_sample), .ladder_bits(ladder_bits),
        .segment_en(segment_en), .update_pulse(update_pulse));
    dird_src i_dird_src (.clk(clk), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_code_bits(sample_code_bits));

    function automatic logic [SEG_N-1:0] therm(input logic [3:0] up);
        logic [SEG_N-1:0] t;
        for (int k = 0; k < SEG_N; k++) t[k] = (up > k);
        return t;
    endfunction : therm

    task automatic stop_test();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic send_one(input logic [SAMPLE_W-1:0] w, input int gap);
        exp_q.push_back(w);
        i_dird_src.send(w, gap);
    endtask : send_one

    initial clk = 1'b0;
    always #2 clk = ~clk;

    // Compare every settled cycle, so outputs must also hold between words
    always @(negedge clk) begin
        if (rst) begin
            last_w = RST_SAMPLE;
            `CHK("reset pulse", 1'b0, update_pulse)
        end else if (update_pulse === 1'b1) begin
            if (exp_q.size() == 0) `CHK("spare update", 1'b0, 1'b1)
            else last_w = exp_q.pop_front();
        end
        `CHK("sample_ready", 1'b1, sample_ready)
        `CHK("held_sample", last_w, held_sample)
        `CHK("ladder_bits", last_w[9:0], ladder_bits)
        `CHK("segment_en", therm(last_w[MSB_POS-:4]), segment_en)
        `CHK("seg count", int'(last_w[13:10]), $countones(segment_en))
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        // Zero, full and half scale plus the segment carry first
        foreach (corner[i]) send_one(corner[i], 1);
        // Every upper code, alternating tight and loose spacing
        for (int k = 0; k < 16; k++)
            send_one({4'(k), 10'($random(seed))}, 1 + (k & 1) * 2);
        for (int k = 0; k < 24; k++)
            send_one(14'($random(seed)), 1 + ($random(seed) & 3));
        repeat (6) @(posedge clk);
        `CHK("pending words", 0, exp_q.size())
        // Mid-run reset must clear the word and still take new samples
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        send_one(FULL_SCALE, 1);
        send_one(14'($random(seed)), 1);
        repeat (6) @(posedge clk);
        `CHK("pending words", 0, exp_q.size())
        stop_test();
    end
endmodule : testbench
`default_nettype wire
